// ==== logic/dmae_pkg.sv ====
/*
 * shared constants and carrier types of the mac/accumulator engine.
 * assumes one core clock and an ahb-lite register bus of 32 data bits.
 */
package dmae_pkg;
    // ********************
    // widths
    // ********************
    localparam int ACC_W = 40;
    localparam int OPND_W = 16;
    localparam int MULT_W = 17;
    localparam int PROD_W = 33;
    localparam int SHCNT_W = 6;
    // ********************
    // register map, byte addresses
    // ********************
    localparam logic [7:0] CFG_ADDR = 8'h00;
    localparam logic [7:0] TRAPEN_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] TRAPEN_RESET = 3'h0;
    // core_config_reg fields
    localparam int FRAC_INT_BIT = 0;
    localparam int SIGN_MODE_BIT = 1;
    localparam int ROUND_MODE_BIT = 2;
    localparam int WR_CLAMP_BIT = 3;
    localparam int CLAMP_WIDTH_BIT = 4;
    localparam int B_CLAMP_BIT = 6;
    localparam int A_CLAMP_BIT = 7;
    // int_control_one fields
    localparam int A_TRAP_BIT = 0;
    localparam int B_TRAP_BIT = 1;
    localparam int CAT_TRAP_BIT = 2;
    // status fields
    localparam int A_GUARD_BIT = 0;
    localparam int B_GUARD_BIT = 1;
    localparam int A_LIMIT_BIT = 2;
    localparam int B_LIMIT_BIT = 3;
    localparam int ANY_GUARD_BIT = 4;
    localparam int ANY_LIMIT_BIT = 5;
    // ********************
    // saturation values
    // ********************
    localparam logic [39:0] MAX39 = 40'h7FFFFFFFFF;
    localparam logic [39:0] MIN39 = 40'h8000000000;
    localparam logic [39:0] MAX31 = 40'h007FFFFFFF;
    localparam logic [39:0] MIN31 = 40'hFF80000000;
    localparam logic [15:0] WR_MAX = 16'h7FFF;
    localparam logic [15:0] WR_MIN = 16'h8000;
    // ********************
    // operations
    // ********************
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_CLR = 4'h1,
        OP_MPY = 4'h2,
        OP_MPYN = 4'h3,
        OP_MAC = 4'h4,
        OP_MSC = 4'h5,
        OP_ADDX = 4'h6,
        OP_LOAD = 4'h7,
        OP_ADDACC = 4'h8,
        OP_SUBACC = 4'h9,
        OP_NEG = 4'hA,
        OP_MCUMUL = 4'hB,
        OP_STORE = 4'hC
    } dmae_op_t;
    typedef struct packed {
        dmae_op_t op;
        logic acc_sel;
        logic [15:0] x;
        logic [15:0] y;
        logic [39:0] shift_in;
        logic [5:0] shift_cnt;
        logic mcu_byte;
        logic mcu_x_signed;
        logic mcu_y_signed;
    } dmae_req_t;
    typedef struct packed {
        logic [15:0] store_data;
        logic store_valid;
        logic [31:0] mcu_result;
        logic mcu_valid;
        logic trap_req;
    } dmae_rsp_t;
endpackage

// ==== logic/dmae_engine.sv ====
/*
 * multiplier, 40-bit adder/subtracter, two accumulators, saturation,
 * overflow flags, data write clamp and ahb-lite register slave.
 * assumes the decoder drives one dmae_req_t per cycle on sys_clk.
 */
// What this block does
// - multiplier operands widen to 17 bits, zero or sign extended by mode
// - 33-bit product sign-extends to 40 bits before the accumulator path
// - fractional mode aligns product as 1.31, integer mode gives integer
// - config register holds frac_int_select and sign_mode_select bits
// - shared multiplier serves mcu multiplies: byte gives 16, word 32 bits
// - adder picks accumulator_a or accumulator_b as source and destination
// - add and load data may be scaled by the barrel shifter first
// - zero input option; add uses true data, subtract complemented data
// - guard flag of target updates every pass: set if bits 39:32 differ, cleared in bit-31 mode
// - guard flag set with its trap enable requests a warning trap
// - limit flags set on range overflow and stay until software clears
// - without saturation the limit flag reports bit 39 overflow
// - without saturation, limit flag with catastrophic enable traps
// - status shows or of guard flags and or of limit flags
// - saturation uses result, overflow, clamp enables and width select
// - bit-39 mode loads max 9.31 value on overflow, sets limit flag
// - bit-31 mode loads max 1.31 value; guard flags never set
// - catastrophic mode wraps but still flags bit 39 overflow
// - inherent accumulator add, subtract and negate need no operand
// - config register holds round_mode_sel and write_clamp_en
// - write clamp forces out-of-range stores (bits 39:31 not all sign) to 0x7FFF or 0x8000, accumulator kept
`timescale 1ns/1ps
`default_nettype none
module dmae_engine (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // decoder side
    input wire dmae_pkg::dmae_req_t req,
    output dmae_pkg::dmae_rsp_t rsp,
    output logic [39:0] accumulator_a,
    output logic [39:0] accumulator_b,
    output logic [5:0] status
);
    // ********************
    // registers
    // ********************
    logic [7:0] core_config_reg;
    logic [2:0] int_control_one;
    logic acc_a_guard_ovf, acc_b_guard_ovf, acc_a_limit_flag, acc_b_limit_flag;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic sel_a;
    assign sel_a = (req.acc_sel == 1'b0);

    // ********************
    // ahb-lite slave
    // ********************
    // zero wait states: write lands one cycle after its address phase
    logic addr_ok;
    assign addr_ok = hsel && hready && htrans[1];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph_wr <= 1'b0;
            ph_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            ph_wr <= addr_ok && hwrite;
            ph_addr <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                unique case (haddr[7:0])
                    dmae_pkg::CFG_ADDR: hrdata <= {24'h000000, core_config_reg};
                    dmae_pkg::TRAPEN_ADDR: hrdata <= {29'h00000000, int_control_one};
                    dmae_pkg::STAT_ADDR: hrdata <= {26'h0000000, status};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_config_reg <= dmae_pkg::CFG_RESET;
            int_control_one <= dmae_pkg::TRAPEN_RESET;
        end else if (ph_wr) begin
            if (ph_addr == dmae_pkg::CFG_ADDR)
                core_config_reg <= hwdata[7:0];
            if (ph_addr == dmae_pkg::TRAPEN_ADDR)
                int_control_one <= hwdata[2:0];
        end
    end
    logic clr_a, clr_b;
    assign clr_a = ph_wr && ph_addr == dmae_pkg::STAT_ADDR && hwdata[dmae_pkg::A_LIMIT_BIT];
    assign clr_b = ph_wr && ph_addr == dmae_pkg::STAT_ADDR && hwdata[dmae_pkg::B_LIMIT_BIT];

    // ********************
    // multiplier and scaler
    // ********************
    logic frac_mode, unsigned_mode, wr_clamp, width31;
    assign frac_mode = !core_config_reg[dmae_pkg::FRAC_INT_BIT];
    assign unsigned_mode = core_config_reg[dmae_pkg::SIGN_MODE_BIT];
    assign wr_clamp = core_config_reg[dmae_pkg::WR_CLAMP_BIT];
    assign width31 = core_config_reg[dmae_pkg::CLAMP_WIDTH_BIT];
    logic [16:0] mx, my;
    logic signed [33:0] mprod;
    logic [32:0] prod33;
    logic [39:0] prod40;
    always_comb begin
        if (req.op == dmae_pkg::OP_MCUMUL) begin
            if (req.mcu_byte) begin
                mx = {{9{req.mcu_x_signed & req.x[7]}}, req.x[7:0]};
                my = {{9{req.mcu_y_signed & req.y[7]}}, req.y[7:0]};
            end else begin
                mx = {req.mcu_x_signed & req.x[15], req.x};
                my = {req.mcu_y_signed & req.y[15], req.y};
            end
        end else begin
            mx = {!unsigned_mode & req.x[15], req.x};
            my = {!unsigned_mode & req.y[15], req.y};
        end
    end
    assign mprod = $signed(mx) * $signed(my);
    assign prod33 = frac_mode ? {mprod[31:0], 1'b0} : mprod[32:0];
    assign prod40 = {{7{prod33[32]}}, prod33};

    // ********************
    // barrel shifter
    // ********************
    // positive count shifts right, negative shifts left
    logic [39:0] shifted;
    logic [5:0] neg_cnt;
    assign neg_cnt = 6'h00 - req.shift_cnt;
    always_comb begin
        if (req.shift_cnt[5])
            shifted = req.shift_in << neg_cnt;
        else
            shifted = $unsigned($signed(req.shift_in) >>> req.shift_cnt);
    end

    // ********************
    // adder / subtracter
    // ********************
    logic [39:0] acc_t, acc_o, opa, opb, opbx, sum;
    logic is_pass, zero_in, do_sub, ov39, guard_raw, ov31, clamp_on, sat31_hit;
    logic [39:0] result;
    logic limit_hit, guard_new;
    assign acc_t = sel_a ? accumulator_a : accumulator_b;
    assign acc_o = sel_a ? accumulator_b : accumulator_a;
    always_comb begin
        is_pass = 1'b1;
        zero_in = 1'b0;
        do_sub = 1'b0;
        opb = 40'h0000000000;
        unique case (req.op)
            dmae_pkg::OP_CLR: zero_in = 1'b1;
            dmae_pkg::OP_MPY: begin
                zero_in = 1'b1;
                opb = prod40;
            end
            dmae_pkg::OP_MPYN: begin
                zero_in = 1'b1;
                do_sub = 1'b1;
                opb = prod40;
            end
            dmae_pkg::OP_MAC: opb = prod40;
            dmae_pkg::OP_MSC: begin
                do_sub = 1'b1;
                opb = prod40;
            end
            dmae_pkg::OP_ADDX: opb = shifted;
            dmae_pkg::OP_LOAD: begin
                zero_in = 1'b1;
                opb = shifted;
            end
            dmae_pkg::OP_ADDACC: opb = acc_o;
            dmae_pkg::OP_SUBACC: begin
                do_sub = 1'b1;
                opb = acc_o;
            end
            dmae_pkg::OP_NEG: begin
                zero_in = 1'b1;
                do_sub = 1'b1;
                opb = acc_t;
            end
            default: is_pass = 1'b0;
        endcase
    end
    // subtract: complemented data with borrow-in low, i.e. carry-in of one
    assign opa = zero_in ? 40'h0000000000 : acc_t;
    assign opbx = do_sub ? ~opb : opb;
    assign sum = opa + opbx + {39'h0000000000, do_sub};
    assign ov39 = (opa[39] == opbx[39]) && (sum[39] != opa[39]);
    // guard flags watch 39:32 only; bit 31 matters just for 1.31 clamping
    assign guard_raw = !((&sum[39:32]) || !(|sum[39:32]));
    assign ov31 = !((&sum[39:31]) || !(|sum[39:31]));
    assign clamp_on = sel_a ? core_config_reg[dmae_pkg::A_CLAMP_BIT]
                            : core_config_reg[dmae_pkg::B_CLAMP_BIT];
    assign sat31_hit = ov39 || ov31;
    // sign of a true result: on bit-39 overflow the operand sign is right
    always_comb begin
        result = sum;
        limit_hit = ov39;
        guard_new = guard_raw;
        if (clamp_on && width31) begin
            guard_new = 1'b0;
            limit_hit = sat31_hit;
            if (sat31_hit)
                result = (ov39 ? opa[39] : sum[39]) ? dmae_pkg::MIN31 : dmae_pkg::MAX31;
        end else if (clamp_on && ov39) begin
            result = opa[39] ? dmae_pkg::MIN39 : dmae_pkg::MAX39;
        end
    end

    // ********************
    // accumulators and flags
    // ********************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            accumulator_a <= 40'h0000000000;
            accumulator_b <= 40'h0000000000;
        end else if (is_pass) begin
            if (sel_a)
                accumulator_a <= result;
            else
                accumulator_b <= result;
        end
    end
    logic next_ga, next_gb, next_la, next_lb;
    always_comb begin
        next_ga = acc_a_guard_ovf;
        next_gb = acc_b_guard_ovf;
        next_la = acc_a_limit_flag && !clr_a;
        next_lb = acc_b_limit_flag && !clr_b;
        if (is_pass && sel_a) begin
            next_ga = guard_new;
            next_la = next_la || limit_hit;
        end
        if (is_pass && !sel_a) begin
            next_gb = guard_new;
            next_lb = next_lb || limit_hit;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_a_guard_ovf <= 1'b0;
            acc_b_guard_ovf <= 1'b0;
            acc_a_limit_flag <= 1'b0;
            acc_b_limit_flag <= 1'b0;
            status <= 6'h00;
        end else begin
            acc_a_guard_ovf <= next_ga;
            acc_b_guard_ovf <= next_gb;
            acc_a_limit_flag <= next_la;
            acc_b_limit_flag <= next_lb;
            status <= {next_la | next_lb, next_ga | next_gb,
                       next_lb, next_la, next_gb, next_ga};
        end
    end

    // ********************
    // traps, mcu product, store
    // ********************
    logic trap_now;
    assign trap_now = (next_ga && !acc_a_guard_ovf && int_control_one[dmae_pkg::A_TRAP_BIT])
        || (next_gb && !acc_b_guard_ovf && int_control_one[dmae_pkg::B_TRAP_BIT])
        || (is_pass && !clamp_on && limit_hit
            && int_control_one[dmae_pkg::CAT_TRAP_BIT]);
    logic st_big;
    assign st_big = (acc_t[39:31] != {9{acc_t[39]}});
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp.trap_req <= trap_now;
            rsp.mcu_valid <= (req.op == dmae_pkg::OP_MCUMUL);
            if (req.op == dmae_pkg::OP_MCUMUL)
                rsp.mcu_result <= req.mcu_byte ? {16'h0000, mprod[15:0]} : mprod[31:0];
            rsp.store_valid <= (req.op == dmae_pkg::OP_STORE);
            if (req.op == dmae_pkg::OP_STORE) begin
                if (wr_clamp && st_big)
                    rsp.store_data <= acc_t[39] ? dmae_pkg::WR_MIN : dmae_pkg::WR_MAX;
                else
                    rsp.store_data <= acc_t[31:16];
            end
        end
    end

    // ********************
    // checks
    // ********************
    property p_guard;
        @(posedge sys_clk) disable iff (rst)
        (is_pass && sel_a && !(clamp_on && width31))
            |=> acc_a_guard_ovf == $past(sum[39:32] != {8{sum[39]}});
    endproperty
    a_guard: assert property (p_guard) else $error("guard flag a wrong");
    property p_sticky;
        @(posedge sys_clk) disable iff (rst)
        (acc_a_limit_flag && !clr_a) |=> acc_a_limit_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("limit flag a dropped");
    property p_cat;
        @(posedge sys_clk) disable iff (rst)
        (is_pass && !clamp_on && ov39 && !sel_a) |=> acc_b_limit_flag && status[5];
    endproperty
    a_cat: assert property (p_cat) else $error("bit 39 overflow not flagged");
    property p_any;
        @(posedge sys_clk) disable iff (rst)
        ##1 status[4] == (acc_a_guard_ovf | acc_b_guard_ovf);
    endproperty
    a_any: assert property (p_any) else $error("any guard mismatch");
    property p_sat39;
        @(posedge sys_clk) disable iff (rst)
        (is_pass && sel_a && clamp_on && !width31 && ov39 && !opa[39])
            |=> accumulator_a == 40'h7FFFFFFFFF;
    endproperty
    a_sat39: assert property (p_sat39) else $error("bit 39 saturation value");
    property p_w31;
        @(posedge sys_clk) disable iff (rst)
        (is_pass && !sel_a && clamp_on && width31) |=> !acc_b_guard_ovf;
    endproperty
    a_w31: assert property (p_w31) else $error("guard set in 1.31 mode");
    property p_trap;
        @(posedge sys_clk) disable iff (rst)
        (is_pass && sel_a && !clamp_on && ov39 && int_control_one[2]) |=> rsp.trap_req;
    endproperty
    a_trap: assert property (p_trap) else $error("catastrophic trap missing");
    property p_store;
        @(posedge sys_clk) disable iff (rst)
        (req.op == dmae_pkg::OP_STORE && wr_clamp && !acc_t[39] && acc_t[38:31] != 8'h00)
            |=> rsp.store_valid && rsp.store_data == 16'h7FFF;
    endproperty
    a_store: assert property (p_store) else $error("store clamp wrong");
    property p_mpy;
        @(posedge sys_clk) disable iff (rst)
        (req.op == dmae_pkg::OP_MPY && sel_a && !clamp_on) |=> accumulator_a == $past(prod40);
    endproperty
    a_mpy: assert property (p_mpy) else $error("multiply not in one cycle");
    property p_trap_b;
        @(posedge sys_clk) disable iff (rst)
        (!acc_b_guard_ovf && int_control_one[dmae_pkg::B_TRAP_BIT]) ##1 acc_b_guard_ovf
            |-> rsp.trap_req;
    endproperty
    a_trap_b: assert property (p_trap_b) else $error("guard trap b missing");
    property p_sticky_b;
        @(posedge sys_clk) disable iff (rst)
        (acc_b_limit_flag && !clr_b) |=> acc_b_limit_flag;
    endproperty
    a_sticky_b: assert property (p_sticky_b) else $error("limit flag b dropped");
    property p_wrmin;
        @(posedge sys_clk) disable iff (rst)
        (req.op == dmae_pkg::OP_STORE && wr_clamp && acc_t[39] && acc_t[38:31] != 8'hFF)
            |=> rsp.store_valid && rsp.store_data == 16'h8000;
    endproperty
    a_wrmin: assert property (p_wrmin) else $error("negative store clamp wrong");
    property p_sat31;
        @(posedge sys_clk) disable iff (rst)
        (is_pass && sel_a && clamp_on && width31 && !ov39 && !sum[39] && sum[38:31] != 8'h00)
            |=> accumulator_a == 40'h007FFFFFFF;
    endproperty
    a_sat31: assert property (p_sat31) else $error("bit 31 saturation value");
endmodule
`default_nettype wire

// ==== tb/dmae_dec_model.sv ====
/*
 * stand-in for the instruction decoder and register file.
 * assumes the engine samples req on every rising edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dmae_dec_model (
    // clock
    input wire logic sys_clk,
    // request to the engine
    output var dmae_pkg::dmae_req_t req
);
    initial req = '0;
    // ********************
    // one operation, one cycle
    // ********************
    // all fields move at one edge; the op drops back to nop afterwards so
    // a level request is never executed twice
    task automatic send(input dmae_pkg::dmae_req_t r);
        @(posedge sys_clk);
        req <= r;
        @(posedge sys_clk);
        req <= '0;
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * self-checking bench of the mac/accumulator engine.
 * assumes zero-wait ahb-lite slave and one-cycle engine passes.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    dmae_pkg::dmae_req_t req;
    dmae_pkg::dmae_rsp_t rsp;
    logic [39:0] accumulator_a;
    logic [39:0] accumulator_b;
    logic [5:0] status;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    assign hready = hreadyout;
    always #4 sys_clk = ~sys_clk;
    dmae_engine u_dmae_engine (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .req(req), .rsp(rsp), .accumulator_a(accumulator_a),
        .accumulator_b(accumulator_b), .status(status));
    dmae_dec_model u_dmae_dec_model (.sys_clk(sys_clk), .req(req));
    // ********************
    // helpers
    // ********************
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, {8'h0, e}, {8'h0, q});
        chk("hresp", 40'h0, {39'h0, hresp});
    endtask
    task automatic op(input dmae_pkg::dmae_op_t o, input logic s, input logic [15:0] x,
        input logic [15:0] y, input logic [39:0] sh, input logic [5:0] c,
        input logic [2:0] m);
        u_dmae_dec_model.send('{o, s, x, y, sh, c, m[2], m[1], m[0]});
        #1;
    endtask
    task automatic ld(input logic s, input logic [39:0] v);
        op(dmae_pkg::OP_LOAD, s, 16'h0, 16'h0, v, 6'h0, 3'h0);
    endtask
    task automatic addx(input logic s, input logic [39:0] v);
        op(dmae_pkg::OP_ADDX, s, 16'h0, 16'h0, v, 6'h0, 3'h0);
    endtask
    task automatic mul(input dmae_pkg::dmae_op_t o, input logic s, input logic [15:0] x,
        input logic [15:0] y);
        op(o, s, x, y, 40'h0, 6'h0, 3'h0);
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_regs();
        chk("acc_a", 40'h0, accumulator_a);
        chk("acc_b", 40'h0, accumulator_b);
        chk("status", 40'h0, {34'h0, status});
        rchk("cfg", dmae_pkg::CFG_ADDR, 32'h0);
        rchk("trapen", dmae_pkg::TRAPEN_ADDR, 32'h0);
        wr(dmae_pkg::CFG_ADDR, 32'hDF);
        wr(8'h0C, 32'hFF);
        rchk("cfg", dmae_pkg::CFG_ADDR, 32'hDF);
        rchk("unmapped", 8'h0C, 32'h0);
        wr(dmae_pkg::CFG_ADDR, 32'h0);
    endtask
    task automatic t_mult();
        mul(dmae_pkg::OP_MPY, 1'b0, 16'h4000, 16'h4000);
        chk("frac", 40'h0020000000, accumulator_a);
        mul(dmae_pkg::OP_MPY, 1'b0, 16'h8000, 16'h8000);
        chk("frac_max", 40'h0080000000, accumulator_a);
        chk("frac_guard", 40'h0, {34'h0, status});
        mul(dmae_pkg::OP_MPYN, 1'b0, 16'h4000, 16'h4000);
        chk("mpyn", 40'hFFE0000000, accumulator_a);
        wr(dmae_pkg::CFG_ADDR, 32'h1);
        mul(dmae_pkg::OP_MPY, 1'b0, 16'hFFFF, 16'h0002);
        chk("int_signed", 40'hFFFFFFFFFE, accumulator_a);
        mul(dmae_pkg::OP_MPY, 1'b1, 16'h3, 16'h4);
        mul(dmae_pkg::OP_MAC, 1'b1, 16'h2, 16'h5);
        chk("mac_b", 40'h16, accumulator_b);
        mul(dmae_pkg::OP_MSC, 1'b1, 16'h1, 16'h2);
        chk("msc_b", 40'h14, accumulator_b);
        wr(dmae_pkg::CFG_ADDR, 32'h3);
        mul(dmae_pkg::OP_MPY, 1'b0, 16'hFFFF, 16'h0002);
        chk("int_unsigned", 40'h1FFFE, accumulator_a);
        wr(dmae_pkg::CFG_ADDR, 32'h0);
    endtask
    task automatic t_acc();
        ld(1'b0, 40'h5);
        ld(1'b1, 40'h3);
        op(dmae_pkg::OP_ADDACC, 1'b0, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("addacc", 40'h8, accumulator_a);
        op(dmae_pkg::OP_SUBACC, 1'b0, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("subacc", 40'h5, accumulator_a);
        op(dmae_pkg::OP_NEG, 1'b1, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("neg", 40'hFFFFFFFFFD, accumulator_b);
        op(dmae_pkg::OP_ADDX, 1'b0, 16'h0, 16'h0, 40'h100, 6'h04, 3'h0);
        chk("addx_right", 40'h15, accumulator_a);
        op(dmae_pkg::OP_LOAD, 1'b0, 16'h0, 16'h0, 40'h1, 6'h3C, 3'h0);
        chk("load_left", 40'h10, accumulator_a);
        op(dmae_pkg::OP_CLR, 1'b0, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("clr", 40'h0, accumulator_a);
    endtask
    task automatic t_flags();
        wr(dmae_pkg::TRAPEN_ADDR, 32'h7);
        ld(1'b0, 40'h0100000000);
        chk("trap", 40'h1, {39'h0, rsp.trap_req});
        chk("status", 40'h11, {34'h0, status});
        ld(1'b0, 40'h0100000000);
        chk("trap", 40'h0, {39'h0, rsp.trap_req});
        ld(1'b1, 40'h0100000000);
        chk("trap_b", 40'h1, {39'h0, rsp.trap_req});
        ld(1'b1, 40'h0);
        ld(1'b0, 40'h0);
        chk("status", 40'h0, {34'h0, status});
        ld(1'b0, dmae_pkg::MAX39);
        addx(1'b0, 40'h1);
        chk("wrap", dmae_pkg::MIN39, accumulator_a);
        chk("status", 40'h35, {34'h0, status});
        chk("trap", 40'h1, {39'h0, rsp.trap_req});
        ld(1'b0, 40'h0);
        chk("status", 40'h24, {34'h0, status});
        wr(dmae_pkg::STAT_ADDR, 32'h4);
        rchk("stat", dmae_pkg::STAT_ADDR, 32'h0);
    endtask
    task automatic t_sat();
        wr(dmae_pkg::CFG_ADDR, 32'h80);
        ld(1'b0, dmae_pkg::MAX39);
        addx(1'b0, 40'h1);
        chk("sat39_pos", dmae_pkg::MAX39, accumulator_a);
        chk("a_limit", 40'h1, {39'h0, status[2]});
        ld(1'b0, dmae_pkg::MIN39);
        addx(1'b0, 40'hFFFFFFFFFF);
        chk("sat39_neg", dmae_pkg::MIN39, accumulator_a);
        wr(dmae_pkg::STAT_ADDR, 32'hC);
        wr(dmae_pkg::CFG_ADDR, 32'h90);
        ld(1'b0, dmae_pkg::MAX31);
        addx(1'b0, 40'h00FFFFFFFF);
        chk("sat31_pos", dmae_pkg::MAX31, accumulator_a);
        chk("status", 40'h24, {34'h0, status});
        wr(dmae_pkg::CFG_ADDR, 32'h50);
        ld(1'b1, dmae_pkg::MIN31);
        addx(1'b1, 40'hFF00000000);
        chk("sat31_neg", dmae_pkg::MIN31, accumulator_b);
        chk("b_limit", 40'h1, {39'h0, status[3]});
        wr(dmae_pkg::STAT_ADDR, 32'hC);
    endtask
    task automatic t_store();
        wr(dmae_pkg::CFG_ADDR, 32'h8);
        ld(1'b0, 40'h0123456789);
        op(dmae_pkg::OP_STORE, 1'b0, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("store_valid", 40'h1, {39'h0, rsp.store_valid});
        chk("store_pos", {24'h0, dmae_pkg::WR_MAX}, {24'h0, rsp.store_data});
        chk("acc_kept", 40'h0123456789, accumulator_a);
        ld(1'b0, 40'hFF00000000);
        op(dmae_pkg::OP_STORE, 1'b0, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("store_neg", {24'h0, dmae_pkg::WR_MIN}, {24'h0, rsp.store_data});
        wr(dmae_pkg::CFG_ADDR, 32'h0);
        ld(1'b0, 40'h0123456789);
        op(dmae_pkg::OP_STORE, 1'b0, 16'h0, 16'h0, 40'h0, 6'h0, 3'h0);
        chk("store_raw", 40'h2345, {24'h0, rsp.store_data});
    endtask
    task automatic t_mcu();
        op(dmae_pkg::OP_MCUMUL, 1'b0, 16'h00FF, 16'h00FF, 40'h0, 6'h0, 3'h4);
        chk("mcu_valid", 40'h1, {39'h0, rsp.mcu_valid});
        chk("mcu_byte", 40'hFE01, {8'h0, rsp.mcu_result});
        op(dmae_pkg::OP_MCUMUL, 1'b0, 16'hFFFF, 16'h0003, 40'h0, 6'h0, 3'h3);
        chk("mcu_word", 40'hFFFFFFFD, {8'h0, rsp.mcu_result});
        op(dmae_pkg::OP_MCUMUL, 1'b0, 16'hFFFF, 16'h0002, 40'h0, 6'h0, 3'h2);
        chk("mcu_mixed", 40'hFFFFFFFE, {8'h0, rsp.mcu_result});
    endtask
    // reset in mid-run, with both accumulators, both registers and guard flag a non-zero
    task automatic t_reset();
        wr(dmae_pkg::CFG_ADDR, 32'hDF);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("acc_a", 40'h0, accumulator_a);
        chk("acc_b", 40'h0, accumulator_b);
        chk("status", 40'h0, {34'h0, status});
        rchk("cfg", dmae_pkg::CFG_ADDR, 32'h0);
        rchk("trapen", dmae_pkg::TRAPEN_ADDR, 32'h0);
    endtask
    // ********************
    // main sequence
    // ********************
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_regs();
        t_mult();
        t_acc();
        t_flags();
        t_sat();
        t_store();
        t_mcu();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
